/* File: hdl/iog_ctrl.sv */
// general control register group: sync event counters, high-voltage pin
// options, regulator options and the output availability override.
// assumes access ports, sync pulses, eeprom loader and al state come from
// logic on CORE_CLK; only PIN_IN arrives from outside and is synchronised.
`timescale 1ns/1ps
module iog_ctrl (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic SYNC_PULSE_OUT_A,
   input wire logic SYNC_PULSE_OUT_B,
   input wire logic LOC_REQ,
   input wire logic LOC_WR,
   input wire logic [7:0] LOC_REG,
   input wire logic [31:0] LOC_WDATA,
   output logic LOC_ACK,
   output logic [31:0] LOC_RDATA,
   input wire logic ECAT_REQ,
   input wire logic ECAT_WR,
   input wire logic [7:0] ECAT_REG,
   output logic ECAT_ACK,
   output logic ECAT_ERR,
   output logic [31:0] ECAT_RDATA,
   input wire logic EE_LOAD,
   input wire logic [27:0] EE_HV_CFG,
   input wire logic [15:0] EE_REG_CFG,
   input wire logic [3:0] AL_STATE,
   input wire logic [23:0] MASTER_OWNED,
   input wire logic [23:0] LOC_OUT_VAL,
   input wire logic ECAT_OUT_WE,
   input wire logic [23:0] ECAT_OUT_VAL,
   input wire logic [23:0] PIN_IN,
   output logic [23:0] LOC_IN_VAL,
   output logic [23:0] ECAT_IN_VAL,
   output logic [23:0] PORT_OUT,
   output logic [23:0] PORT_OUT_EN,
   output iog_pkg::iog_hv_cfg_t HV_CFG,
   output iog_pkg::iog_reg_cfg_t REG_CFG,
   output logic OVERRIDE
);

   // counter state
   logic sync_a_q;
   logic sync_b_q;
   logic [15:0] cnt_a;
   logic [15:0] cnt_b;
   logic next_sync_a_q;
   logic next_sync_b_q;
   logic [15:0] next_cnt_a;
   logic [15:0] next_cnt_b;
   logic evt_a;
   logic evt_b;

   // configuration state
   iog_pkg::iog_hv_cfg_t hv_cfg;
   iog_pkg::iog_reg_cfg_t reg_cfg;
   logic ovr;
   iog_pkg::iog_hv_cfg_t next_hv_cfg;
   iog_pkg::iog_reg_cfg_t next_reg_cfg;
   logic next_ovr;

   // access port state
   logic loc_ack;
   logic [31:0] loc_rdata;
   logic ecat_ack;
   logic ecat_err;
   logic [31:0] ecat_rdata;
   logic next_loc_ack;
   logic [31:0] next_loc_rdata;
   logic next_ecat_ack;
   logic next_ecat_err;
   logic [31:0] next_ecat_rdata;
   logic loc_wr_hv;
   logic loc_wr_reg;
   logic loc_wr_ovr;
   logic ecat_cfg_hit;

   // i/o port state
   logic [23:0] pin_meta;
   logic [23:0] pin_sync;
   logic [23:0] loc_in;
   logic [23:0] ecat_in;
   logic [23:0] master_val;
   logic [23:0] port_out;
   logic [23:0] port_en;
   logic [23:0] next_loc_in;
   logic [23:0] next_ecat_in;
   logic [23:0] next_master_val;
   logic [23:0] next_port_out;
   logic [23:0] next_port_en;
   logic al_op;
   logic al_safe_or_op;

   // sync event counters; a read path has no hook into this process
   always_comb begin
      next_sync_a_q = SYNC_PULSE_OUT_A;
      next_sync_b_q = SYNC_PULSE_OUT_B;
      evt_a = SYNC_PULSE_OUT_A & ~sync_a_q;
      evt_b = SYNC_PULSE_OUT_B & ~sync_b_q;
      next_cnt_a = cnt_a;
      next_cnt_b = cnt_b;
      if (evt_a) begin
         next_cnt_a = cnt_a + 16'h0001;
      end
      if (evt_b) begin
         next_cnt_b = cnt_b + 16'h0001;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         sync_a_q <= 1'b0;
         sync_b_q <= 1'b0;
         cnt_a <= iog_pkg::CNT_RESET;
         cnt_b <= iog_pkg::CNT_RESET;
      end else begin
         sync_a_q <= next_sync_a_q;
         sync_b_q <= next_sync_b_q;
         cnt_a <= next_cnt_a;
         cnt_b <= next_cnt_b;
      end
   end

   // configuration writes; only the local port can reach them
   always_comb begin
      loc_wr_hv = LOC_REQ & LOC_WR & (LOC_REG == iog_pkg::REG_HV_CFG);
      loc_wr_reg = LOC_REQ & LOC_WR & (LOC_REG == iog_pkg::REG_REG_CFG);
      loc_wr_ovr = LOC_REQ & LOC_WR & (LOC_REG == iog_pkg::REG_OVERRIDE);
      next_hv_cfg = hv_cfg;
      next_reg_cfg = reg_cfg;
      next_ovr = ovr;
      // eeprom preload first, so a local write in the same cycle wins
      if (EE_LOAD) begin
         next_hv_cfg = EE_HV_CFG;
         next_reg_cfg = EE_REG_CFG & iog_pkg::REG_WMASK;
      end
      if (loc_wr_hv) begin
         next_hv_cfg = LOC_WDATA[iog_pkg::HV_USED_BITS-1:0];
      end
      if (loc_wr_reg) begin
         next_reg_cfg = LOC_WDATA[15:0] & iog_pkg::REG_WMASK;
      end
      if (loc_wr_ovr) begin
         next_ovr = LOC_WDATA[iog_pkg::OVR_BIT];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         hv_cfg <= iog_pkg::HV_RESET;
         reg_cfg <= iog_pkg::REG_RESET;
         ovr <= iog_pkg::OVR_RESET;
      end else begin
         hv_cfg <= next_hv_cfg;
         reg_cfg <= next_reg_cfg;
         ovr <= next_ovr;
      end
   end

   // read answers; config registers are write-only and read as zero
   always_comb begin
      next_loc_ack = LOC_REQ;
      next_loc_rdata = 32'h00000000;
      if (LOC_REQ & ~LOC_WR & (LOC_REG == iog_pkg::REG_SYNC_CNT)) begin
         next_loc_rdata = {cnt_b, cnt_a};
      end
      ecat_cfg_hit = (ECAT_REG == iog_pkg::REG_HV_CFG) |
                     (ECAT_REG == iog_pkg::REG_REG_CFG) |
                     (ECAT_REG == iog_pkg::REG_OVERRIDE);
      next_ecat_ack = ECAT_REQ;
      // master gets a refusal instead of touching config state
      next_ecat_err = ECAT_REQ & (ecat_cfg_hit | ECAT_WR);
      next_ecat_rdata = 32'h00000000;
      if (ECAT_REQ & ~ECAT_WR & (ECAT_REG == iog_pkg::REG_SYNC_CNT)) begin
         next_ecat_rdata = {cnt_b, cnt_a};
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         loc_ack <= 1'b0;
         loc_rdata <= 32'h00000000;
         ecat_ack <= 1'b0;
         ecat_err <= 1'b0;
         ecat_rdata <= 32'h00000000;
      end else begin
         loc_ack <= next_loc_ack;
         loc_rdata <= next_loc_rdata;
         ecat_ack <= next_ecat_ack;
         ecat_err <= next_ecat_err;
         ecat_rdata <= next_ecat_rdata;
      end
   end

   // pin synchroniser; pin_meta feeds pin_sync only
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         pin_meta <= 24'h000000;
         pin_sync <= 24'h000000;
      end else begin
         pin_meta <= PIN_IN;
         pin_sync <= pin_meta;
      end
   end

   // port gating against al state and the override
   always_comb begin
      al_op = (AL_STATE == iog_pkg::AL_OP);
      al_safe_or_op = al_op | (AL_STATE == iog_pkg::AL_SAFEOP);
      next_loc_in = pin_sync;
      next_ecat_in = pin_sync & MASTER_OWNED & {24{al_safe_or_op}};
      next_master_val = master_val;
      if (ECAT_OUT_WE & al_op) begin
         // master values only land on its own ports, and only in op
         next_master_val = (master_val & ~MASTER_OWNED) |
                           (ECAT_OUT_VAL & MASTER_OWNED);
      end
      if (ovr) begin
         // al state ignored, every port driven from the local side
         next_port_en = 24'hffffff;
         next_port_out = LOC_OUT_VAL;
      end else begin
         next_port_en = {24{al_op}};
         next_port_out = (master_val & MASTER_OWNED) | (LOC_OUT_VAL & ~MASTER_OWNED);
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         loc_in <= 24'h000000;
         ecat_in <= 24'h000000;
         master_val <= 24'h000000;
         port_out <= 24'h000000;
         port_en <= 24'h000000;
      end else begin
         loc_in <= next_loc_in;
         ecat_in <= next_ecat_in;
         master_val <= next_master_val;
         port_out <= next_port_out;
         port_en <= next_port_en;
      end
   end

   // outputs; the override reaches only output gating, inputs never see it
   assign LOC_ACK = loc_ack;
   assign LOC_RDATA = loc_rdata;
   assign ECAT_ACK = ecat_ack;
   assign ECAT_ERR = ecat_err;
   assign ECAT_RDATA = ecat_rdata;
   assign LOC_IN_VAL = loc_in;
   assign ECAT_IN_VAL = ecat_in;
   assign PORT_OUT = port_out;
   assign PORT_OUT_EN = port_en;
   assign HV_CFG = hv_cfg;
   assign REG_CFG = reg_cfg;
   assign OVERRIDE = ovr;

   // checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence s_cnt_rd;
      LOC_REQ && !LOC_WR && LOC_REG == iog_pkg::REG_SYNC_CNT;
   endsequence

   sequence s_ecat_cfg_wr;
      ECAT_REQ && ECAT_WR && ECAT_REG == iog_pkg::REG_HV_CFG;
   endsequence

   sequence s_no_al;
      !ovr && AL_STATE != iog_pkg::AL_OP;
   endsequence

   chk_cnt_a_wrap: assert property (evt_a |=> cnt_a == 16'($past(cnt_a) + 16'h0001))
      else $error("sync a counter did not step by one");
   chk_cnt_no_clear: assert property (s_cnt_rd ##0 !evt_b |=> cnt_b == $past(cnt_b))
      else $error("sync b counter changed on read");
   chk_cnt_read: assert property (s_cnt_rd |=> LOC_ACK &&
      LOC_RDATA == {$past(cnt_b), $past(cnt_a)})
      else $error("counter read returned wrong halves");
   chk_hv_write: assert property (loc_wr_hv |=> HV_CFG == $past(LOC_WDATA[27:0]))
      else $error("hv config not loaded from local write");
   chk_reg_rsvd: assert property (loc_wr_reg |=>
      REG_CFG == ($past(LOC_WDATA[15:0]) & 16'hff7f))
      else $error("regulator config or reserved bit wrong");
   chk_ecat_refuse: assert property (s_ecat_cfg_wr ##0 (!loc_wr_hv && !EE_LOAD) |=>
      ECAT_ERR && $stable(HV_CFG))
      else $error("master reached hv config");
   chk_ee_preload: assert property (EE_LOAD && !LOC_REQ |=> HV_CFG == $past(EE_HV_CFG))
      else $error("eeprom preload not taken");
   chk_out_gate: assert property (s_no_al |=> PORT_OUT_EN == 24'h000000)
      else $error("outputs active outside op");
   chk_ovr_full: assert property (ovr |=> PORT_OUT_EN == 24'hffffff &&
      PORT_OUT == $past(LOC_OUT_VAL))
      else $error("override did not free outputs");
   chk_in_gate: assert property (!al_safe_or_op |=> ECAT_IN_VAL == 24'h000000)
      else $error("master saw inputs outside safeop or op");
   chk_master_out: assert property (ECAT_OUT_WE && !al_op |=>
      $stable(master_val))
      else $error("master value taken outside op");

   // roll-over from all ones; a short run never gets there, so the step
   // checks carry most of the weight and these guard against saturation
   sequence s_cnt_a_top;
      evt_a && cnt_a == 16'hffff;
   endsequence
   sequence s_cnt_b_top;
      evt_b && cnt_b == 16'hffff;
   endsequence

   chk_cnt_a_roll: assert property (s_cnt_a_top |=> cnt_a == 16'h0000)
      else $error("sync a counter did not wrap to zero");
   chk_cnt_b_roll: assert property (s_cnt_b_top |=> cnt_b == 16'h0000)
      else $error("sync b counter did not wrap to zero");
   chk_cnt_b_step: assert property (evt_b |=> cnt_b == 16'($past(cnt_b) + 16'h0001))
      else $error("sync b counter did not step by one");

   // fieldbus read of the counters: answered, not refused, both halves placed
   sequence s_ecat_cnt_rd;
      ECAT_REQ && !ECAT_WR && ECAT_REG == iog_pkg::REG_SYNC_CNT;
   endsequence

   chk_ecat_read: assert property (s_ecat_cnt_rd |=> ECAT_ACK && !ECAT_ERR &&
      ECAT_RDATA == {$past(cnt_b), $past(cnt_a)})
      else $error("fieldbus counter read wrong");

   // each option field lands at its own position of the written word
   chk_reg_freq: assert property (loc_wr_reg |=>
      REG_CFG.fixed_reg_freq_sel == $past(LOC_WDATA[1:0]) &&
      REG_CFG.adj_reg_freq_sel == $past(LOC_WDATA[9:8]))
      else $error("regulator frequency field misplaced");
   chk_reg_gain: assert property (loc_wr_reg |=>
      REG_CFG.fixed_reg_gain_sel == $past(LOC_WDATA[3:2]) &&
      REG_CFG.adj_reg_gain_sel == $past(LOC_WDATA[11:10]))
      else $error("regulator gain field misplaced");
   chk_hv_pairs: assert property (loc_wr_hv |=>
      HV_CFG.diff_pair_enable == $past(LOC_WDATA[27:24]))
      else $error("pair enables misplaced");

   // fieldbus attempts on the override or regulator word leave them alone
   sequence s_ecat_ovr_try;
      ECAT_REQ && ECAT_REG == iog_pkg::REG_OVERRIDE && !loc_wr_ovr;
   endsequence
   sequence s_ecat_reg_try;
      ECAT_REQ && ECAT_REG == iog_pkg::REG_REG_CFG && !loc_wr_reg && !EE_LOAD;
   endsequence

   chk_ovr_write: assert property (loc_wr_ovr |=> OVERRIDE == $past(LOC_WDATA[0]))
      else $error("override bit not taken from local write");
   chk_ecat_no_ovr: assert property (s_ecat_ovr_try |=> ECAT_ERR && $stable(OVERRIDE))
      else $error("master reached the override");
   chk_ecat_no_reg: assert property (s_ecat_reg_try |=> ECAT_ERR && $stable(REG_CFG))
      else $error("master reached regulator config");

   // port gating in op, and the inputs that always reach the local side
   chk_out_op: assert property (!ovr && al_op |=>
      PORT_OUT_EN == 24'hffffff)
      else $error("outputs not active in op");
   chk_loc_in: assert property (1'b1 |=> LOC_IN_VAL == $past(pin_sync))
      else $error("local side lost an input");
   chk_in_open: assert property (al_safe_or_op |=>
      ECAT_IN_VAL == ($past(pin_sync) & $past(MASTER_OWNED)))
      else $error("master input view wrong in safeop or op");
   chk_master_land: assert property (ECAT_OUT_WE && al_op |=>
      (master_val & $past(MASTER_OWNED)) == ($past(ECAT_OUT_VAL) & $past(MASTER_OWNED)))
      else $error("master value not taken in op");

endmodule

/* File: hdl/iog_pkg.sv */
// package for the i/o general control register group: register numbers,
// field positions, reset values, field encodings and carrier structs.
// assumes register numbers arrive unchanged on both access ports.
package iog_pkg;

   // register numbers as seen on the local and fieldbus access ports
   localparam logic [7:0] REG_SYNC_CNT = 8'h3f;
   localparam logic [7:0] REG_HV_CFG = 8'h40;
   localparam logic [7:0] REG_REG_CFG = 8'h41;
   localparam logic [7:0] REG_OVERRIDE = 8'h42;

   // field positions
   localparam int CNT_A_LSB = 0;
   localparam int CNT_B_LSB = 16;
   localparam int HV_USED_BITS = 28;
   localparam int OVR_BIT = 0;
   localparam int NUM_PORTS = 24;

   // reset values and the regulator write mask
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [27:0] HV_RESET = 28'h0000000;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] REG_WMASK = 16'hff7f;
   localparam logic OVR_RESET = 1'b0;

   // application-layer state codes of the slave state machine
   localparam logic [3:0] AL_SAFEOP = 4'h4;
   localparam logic [3:0] AL_OP = 4'h8;

   // regulator switching frequency encoding
   typedef enum logic [1:0] {
      IOG_F250K = 2'h0,
      IOG_F125K = 2'h1,
      IOG_F500K = 2'h2,
      IOG_F1M = 2'h3
   } iog_freq_t;

   // feedback gain and dampening encoding
   typedef enum logic [1:0] {
      IOG_P100 = 2'h0,
      IOG_P150 = 2'h1,
      IOG_P200 = 2'h2,
      IOG_P50 = 2'h3
   } iog_pct_t;

   // high-voltage pin options, msb first as in the register
   typedef struct packed {
      logic [3:0] diff_pair_enable;
      logic [7:0] reduced_pulldown_drive;
      logic [7:0] reduced_pullup_drive;
      logic [7:0] slew_reduce_bits;
   } iog_hv_cfg_t;

   // regulator options, msb first as in the register
   typedef struct packed {
      logic adj_reg_off;
      logic adj_reg_ocp_off;
      iog_pct_t adj_reg_damp_sel;
      iog_pct_t adj_reg_gain_sel;
      iog_freq_t adj_reg_freq_sel;
      logic rsvd;
      logic fixed_reg_ocp_off;
      iog_pct_t fixed_reg_damp_sel;
      iog_pct_t fixed_reg_gain_sel;
      iog_freq_t fixed_reg_freq_sel;
   } iog_reg_cfg_t;

endpackage

/* File: sim/iog_host.sv */
// local host model: drives the local control port of the register group.
// assumes a free-running clock and one access at a time.
`timescale 1ns/1ps
module iog_host (
   input wire logic clk,
   output logic loc_req,
   output logic loc_wr,
   output logic [7:0] loc_reg,
   output logic [31:0] loc_wdata,
   input wire logic loc_ack,
   input wire logic [31:0] loc_rdata
);
   int to_cnt = 0;
   // idle port at time zero
   initial begin
      loc_req = 1'b0;
      loc_wr = 1'b0;
      loc_reg = 8'h00;
      loc_wdata = 32'h0;
   end
   // one-cycle request, then a bounded wait for the acknowledge
   task automatic acc(input logic wr, input logic [7:0] rg, input logic [31:0] wd,
      output logic [31:0] rd);
      int i;
      @(posedge clk);
      #1;
      loc_req = 1'b1;
      loc_wr = wr;
      loc_reg = rg;
      loc_wdata = wd;
      @(posedge clk);
      #1;
      loc_req = 1'b0;
      loc_reg = ~rg; // released lines must not keep the old value
      loc_wdata = ~wd;
      for (i = 0; i < 4 && loc_ack !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      if (loc_ack !== 1'b1) to_cnt++;
      rd = loc_rdata;
   endtask
endmodule

/* File: sim/tb_top.sv */
// testbench for the general control register group.
// assumes iog_host drives the local port; the bench drives all else.
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sa = 1'b0, sb = 1'b0, ereq = 1'b0, ewr = 1'b0, eel = 1'b0, ewe = 1'b0;
   logic [7:0] ereg = 8'h00;
   logic [27:0] ee_hv = 28'h0;
   logic [15:0] ee_rg = 16'h0;
   logic [3:0] al = 4'h0;
   logic [23:0] own = 24'h0, lov = 24'h0, eov = 24'h0, pin = 24'h0;
   logic lreq, lwr, lack, eack, eerr, ovr;
   logic [7:0] lreg;
   logic [31:0] lwd, lrd, erd, rd, base;
   logic [23:0] liv, eiv, pout, pen;
   iog_pkg::iog_hv_cfg_t hv;
   iog_pkg::iog_reg_cfg_t rc;
   int err_total = 0, total_checks = 0;
   // free-running core clock
   initial forever #4 clk = ~clk;
   iog_host host (.clk(clk), .loc_req(lreq), .loc_wr(lwr), .loc_reg(lreg), .loc_wdata(lwd),
      .loc_ack(lack), .loc_rdata(lrd));
   iog_ctrl uut (.CORE_CLK(clk), .RST(rst), .SYNC_PULSE_OUT_A(sa), .SYNC_PULSE_OUT_B(sb),
      .LOC_REQ(lreq), .LOC_WR(lwr), .LOC_REG(lreg), .LOC_WDATA(lwd), .LOC_ACK(lack),
      .LOC_RDATA(lrd), .ECAT_REQ(ereq), .ECAT_WR(ewr), .ECAT_REG(ereg), .ECAT_ACK(eack),
      .ECAT_ERR(eerr), .ECAT_RDATA(erd), .EE_LOAD(eel), .EE_HV_CFG(ee_hv),
      .EE_REG_CFG(ee_rg), .AL_STATE(al), .MASTER_OWNED(own), .LOC_OUT_VAL(lov),
      .ECAT_OUT_WE(ewe), .ECAT_OUT_VAL(eov), .PIN_IN(pin), .LOC_IN_VAL(liv),
      .ECAT_IN_VAL(eiv), .PORT_OUT(pout), .PORT_OUT_EN(pen), .HV_CFG(hv), .REG_CFG(rc),
      .OVERRIDE(ovr));
   task automatic results;
      $display("checks=%0d mismatches=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // inputs move 1 ns after the edge so sampling never races
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rw(input logic wr, input logic [7:0] rg, input logic [31:0] wd);
      host.acc(wr, rg, wd, rd);
      if (host.to_cnt != 0) begin
         err_total++;
         results();
      end
   endtask
   task automatic ea(input logic wr, input logic [7:0] rg);
      int i;
      // one free edge first, so back to back calls never rewrite ereq in one step
      cyc(1);
      ewr = wr;
      ereg = rg;
      ereq = 1'b1;
      cyc(1);
      ereq = 1'b0;
      ereg = ~rg;
      for (i = 0; i < 4 && eack !== 1'b1; i++) cyc(1);
      if (eack !== 1'b1) begin
         err_total++;
         results();
      end
   endtask
   task automatic pulse(ref logic s, input int n);
      repeat (n) begin
         s = 1'b1;
         cyc(1);
         s = 1'b0;
         cyc(1);
      end
   endtask
   task automatic t_cfg;
      int v;
      rw(1'b1, iog_pkg::REG_HV_CFG, 32'hffffffff);
      chk({4'h0, hv}, 32'h0fffffff);
      rw(1'b1, iog_pkg::REG_HV_CFG, 32'h01020304);
      chk(hv.slew_reduce_bits, 8'h04);
      chk(hv.reduced_pullup_drive, 8'h03);
      chk(hv.reduced_pulldown_drive, 8'h02);
      chk(hv.diff_pair_enable, 4'h1);
      for (v = 0; v < 4; v++) begin
         rw(1'b1, iog_pkg::REG_REG_CFG, {16'h0, {8{v[1:0]}}});
         chk(rc.fixed_reg_freq_sel, v);
         chk(rc.fixed_reg_gain_sel, v);
         chk(rc.adj_reg_gain_sel, v);
         chk(rc.fixed_reg_damp_sel, v);
         chk(rc.adj_reg_damp_sel, v);
         chk(rc.fixed_reg_ocp_off, v[0]);
         chk(rc.adj_reg_ocp_off, v[0]);
         chk(rc.adj_reg_freq_sel, v);
         chk(rc.adj_reg_off, v[1]);
         chk(rc.rsvd, 1'b0);
      end
      $display("test cfg done");
   endtask
   task automatic t_ecat;
      int r;
      rw(1'b1, iog_pkg::REG_OVERRIDE, 32'h1);
      chk(ovr, 1'b1);
      for (r = 64; r < 67; r++) begin
         ea(1'b1, r[7:0]);
         chk(eerr, 1'b1);
         ea(1'b0, r[7:0]);
         chk(eerr, 1'b1);
      end
      chk(ovr, 1'b1);
      chk({4'h0, hv}, 32'h01020304);
      chk(rc, 16'hff7f);
      rw(1'b1, iog_pkg::REG_OVERRIDE, 32'hfe);
      chk(ovr, 1'b0);
      $display("test fieldbus done");
   endtask
   task automatic t_cnt;
      rw(1'b0, iog_pkg::REG_SYNC_CNT, 32'h0);
      base = rd;
      pulse(sa, 3);
      pulse(sb, 5);
      rw(1'b0, iog_pkg::REG_SYNC_CNT, 32'h0);
      chk(rd, {base[31:16] + 16'h5, base[15:0] + 16'h3});
      rw(1'b0, iog_pkg::REG_SYNC_CNT, 32'h0);
      chk(rd, {base[31:16] + 16'h5, base[15:0] + 16'h3});
      ea(1'b0, iog_pkg::REG_SYNC_CNT);
      chk(eerr, 1'b0);
      chk(erd, rd);
      $display("test counters done");
   endtask
   task automatic t_ee;
      ee_hv = 28'h8421537;
      ee_rg = 16'hffff;
      eel = 1'b1;
      cyc(1);
      eel = 1'b0;
      cyc(1);
      chk({4'h0, hv}, 32'h08421537);
      chk(rc, 16'hff7f);
      $display("test preload done");
   endtask
   task automatic t_ports;
      pin = 24'ha5a5a5;
      own = 24'hff00ff;
      lov = 24'h123456;
      cyc(4);
      chk(liv, pin);
      chk(eiv, 24'h0);
      chk(pen, 24'h0);
      al = iog_pkg::AL_SAFEOP;
      eov = 24'hfedcba;
      ewe = 1'b1;
      cyc(1);
      ewe = 1'b0;
      cyc(2);
      chk(eiv, pin & own);
      chk(pen, 24'h0);
      al = iog_pkg::AL_OP;
      cyc(3);
      chk(pen, 24'hffffff);
      chk(pout, lov & ~own);
      ewe = 1'b1;
      cyc(1);
      ewe = 1'b0;
      cyc(2);
      chk(pout, (eov & own) | (lov & ~own));
      rw(1'b1, iog_pkg::REG_OVERRIDE, 32'h1);
      al = 4'h0;
      cyc(3);
      chk(pen, 24'hffffff);
      chk(pout, lov);
      chk(liv, pin);
      rw(1'b1, iog_pkg::REG_OVERRIDE, 32'h0);
      cyc(2);
      chk(pen, 24'h0);
      $display("test ports done");
   endtask
   // guard against a hang anywhere in the sequence
   initial begin
      #400000;
      err_total++;
      results();
   end
   // main sequence
   initial begin
      cyc(20);
      rst = 1'b0;
      chk({4'h0, hv}, 32'h0);
      chk(pen, 24'h0);
      t_cfg();
      t_ecat();
      t_cnt();
      t_ee();
      t_ports();
      results();
   end
endmodule
